// ---- inc/emibs_pkg.sv ----
// shared constants, state codes and helpers of the external memory bus sequencer
package emibs_pkg;

    // width of the phase timer, which counts system clock cycles
    localparam int          CNT_W          = 8;

    // values the timing setup takes after reset
    localparam logic [4:0]  RD_WAIT_RST    = 5'h1f;
    localparam logic [4:0]  RD_DLY_RST     = 5'h01;
    localparam logic [4:0]  WR_WAIT_RST    = 5'h1f;
    localparam logic [4:0]  WR_DLY_RST     = 5'h00;
    localparam logic        RATIO_ONE_RST  = 1'b0;
    localparam logic        ALE_TWO_RST    = 1'b0;
    localparam logic        MUX16_RST      = 1'b0;

    // fixed phase lengths in half bus cycles
    localparam logic [7:0]  H_ADDR_LEAD    = 8'h01;
    localparam logic [7:0]  H_ALE_HOLD     = 8'h01;
    localparam logic [7:0]  H_WR_HOLD      = 8'h01;
    localparam logic [7:0]  H_BYTE2_LATE   = 8'h01;
    localparam logic [7:0]  H_ALE_ONE      = 8'h02;
    localparam logic [7:0]  H_ALE_TWO      = 8'h04;
    localparam logic [7:0]  H_STRB_MIN     = 8'h02;

    // sequencer phases, one-hot
    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_ALEAD = 8'h02,
        ST_ALE   = 8'h04,
        ST_AHOLD = 8'h08,
        ST_SLATE = 8'h10,
        ST_CSW   = 8'h20,
        ST_STRB  = 8'h40,
        ST_WHOLD = 8'h80
    } emibs_state_e;

    // half bus cycles to system clock cycles
    function automatic logic [7:0] emibs_cycles(input logic [7:0] halves,
                                                input logic       ratio_one);
        logic [8:0] sum;
        sum = {1'b0, halves} + 9'h001;
        emibs_cycles = ratio_one ? sum[8:1] : halves;
    endfunction : emibs_cycles

    // subtraction that stops at zero
    function automatic logic [7:0] emibs_sub_sat(input logic [7:0] a,
                                                 input logic [7:0] b);
        emibs_sub_sat = (a > b) ? (a - b) : 8'h00;
    endfunction : emibs_sub_sat

endpackage : emibs_pkg

// ---- verilog/emibs_phase_timer.sv ----
// down counter that times one phase of the memory bus sequence
`timescale 1ns/10ps
`default_nettype none
module emibs_phase_timer
    import emibs_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             arst_n,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] load_val,
    output logic                  last
);
    logic [CNT_W-1:0] cnt_q;

    // reload on each phase entry, count down to zero
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 8'h00;
        end else if (load) begin
            cnt_q <= load_val;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end

    // final cycle of the running phase
    assign last = (cnt_q == 8'h01);
endmodule : emibs_phase_timer
`default_nettype wire

// ---- verilog/emibs_sequencer.sv ----
// external static memory bus sequencer: strobes, address latch and byte splitting
// Contract
// (RULE1) bus clock is the system clock times one half by default, or times one
// (RULE2) address latch strobe lasts one bus cycle by default, two when chosen
// (RULE3) read strobe lasts read wait count minus read delay plus one cycles
// (RULE4) read strobe follows chip select by read delay; address valid that long
// (RULE5) read strobe and chip select are released on the same edge
// (RULE6) multiplexed address stands through latch strobe and half a cycle after
// (RULE7) write strobe lasts write wait count minus write delay plus one cycles
// (RULE8) write strobe follows select by write delay; address and data half earlier
// (RULE9) wide write on byte bus becomes two cycles; second address half late
// (RULE10) byte bus without multiplexing, or sixteen bit multiplexed address and data
// (RULE11) write strobe ends half a cycle before select; data held that half
// (RULE12) memory gives read data before strobe end and holds it until then
`timescale 1ns/10ps
`default_nettype none
module emibs_sequencer
    import emibs_pkg::*;
#(
    parameter int ADDR_W = 24
) (
    input  wire logic              clock,
    input  wire logic              arst_n,
    // timing setup
    input  wire logic              cfg_write,
    input  wire logic              cfg_ratio_one,
    input  wire logic              cfg_ale_two,
    input  wire logic              cfg_mux16,
    input  wire logic [4:0]        cfg_read_wait_count,
    input  wire logic [4:0]        cfg_read_strobe_delay,
    input  wire logic [4:0]        cfg_write_wait_count,
    input  wire logic [4:0]        cfg_write_strobe_delay,
    // system side requests
    input  wire logic              req,
    input  wire logic              req_write,
    input  wire logic              req_wide,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [15:0]       req_wdata,
    output logic                   busy,
    output logic                   done,
    output logic [15:0]            rdata,
    output logic                   bus_ratio_one,
    // external memory pins
    output logic                   chip_select_n,
    output logic                   read_strobe_n,
    output logic                   write_strobe_n,
    output logic                   addr_latch,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic [15:0]            mem_data_o,
    output logic                   mem_data_oe,
    input  wire logic [15:0]       mem_data_i
);
    emibs_state_e      st_q, st_d;
    logic              ratio_one_q, ale_two_q, mux16_q;
    logic [4:0]        rd_wait_q, rd_dly_q, wr_wait_q, wr_dly_q;
    logic              wr_q, split_q, second_q;
    logic [15:0]       wdata_q;
    logic              busy_q, done_q, cs_n_q, rd_n_q, wr_n_q, ale_q, oe_q;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [15:0]       dout_q, dout_d, rdata_q;

    wire               last;
    wire               start   = (st_q == ST_IDLE) && req;
    wire               advance = (st_q != ST_IDLE) && last;
    wire               w       = (st_q == ST_IDLE) ? req_write : wr_q;

    // timing setup, held steady while a transfer runs
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ratio_one_q <= RATIO_ONE_RST;
            ale_two_q   <= ALE_TWO_RST;
            mux16_q     <= MUX16_RST;
            rd_wait_q   <= RD_WAIT_RST;
            rd_dly_q    <= RD_DLY_RST;
            wr_wait_q   <= WR_WAIT_RST;
            wr_dly_q    <= WR_DLY_RST;
        end else if (cfg_write && (st_q == ST_IDLE) && !req) begin
            ratio_one_q <= cfg_ratio_one;
            ale_two_q   <= cfg_ale_two;
            mux16_q     <= cfg_mux16;
            rd_wait_q   <= cfg_read_wait_count;
            rd_dly_q    <= cfg_read_strobe_delay;
            wr_wait_q   <= cfg_write_wait_count;
            wr_dly_q    <= cfg_write_strobe_delay;
        end
    end

    // phase lengths in half bus cycles
    wire [4:0] dly    = w ? wr_dly_q : rd_dly_q;
    wire [4:0] wait_c = w ? wr_wait_q : rd_wait_q;
    wire [7:0] d2     = {2'b00, dly, 1'b0};
    wire [7:0] ale_h  = ale_two_q ? H_ALE_TWO : H_ALE_ONE;                 // see (RULE2)
    wire [7:0] csw_mux = emibs_sub_sat(d2, ale_h + H_ALE_HOLD);            // see (RULE6)
    wire [7:0] csw_b2  = emibs_sub_sat(d2, H_BYTE2_LATE);                  // see (RULE9)
    wire [7:0] csw_h  = (st_q == ST_SLATE) ? csw_b2 :
                        mux16_q ? csw_mux : d2;                            // see (RULE4) (RULE8)
    wire [7:0] span   = {3'b000, wait_c} - {3'b000, dly} + 8'h01;
    wire [7:0] strb_h = (wait_c >= dly) ? {span[6:0], 1'b0} : H_STRB_MIN;  // see (RULE3) (RULE7)
    wire       csw_zero = (csw_h == 8'h00);

    // phase sequencing
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (req) begin
                    if (mux16_q) begin
                        st_d = ST_ALE;                                     // see (RULE10)
                    end else if (req_write) begin
                        st_d = ST_ALEAD;                                   // see (RULE8)
                    end else begin
                        st_d = csw_zero ? ST_STRB : ST_CSW;                // see (RULE4)
                    end
                end
            end
            ST_ALEAD: if (advance) st_d = csw_zero ? ST_STRB : ST_CSW;
            ST_ALE:   if (advance) st_d = ST_AHOLD;                        // see (RULE6)
            ST_AHOLD: if (advance) st_d = csw_zero ? ST_STRB : ST_CSW;
            ST_SLATE: if (advance) st_d = csw_zero ? ST_STRB : ST_CSW;
            ST_CSW:   if (advance) st_d = ST_STRB;
            ST_STRB:  if (advance) st_d = wr_q ? ST_WHOLD : ST_IDLE;       // see (RULE5) (RULE11)
            ST_WHOLD: if (advance) st_d = (split_q && !second_q) ? ST_SLATE : ST_IDLE;
            default:  st_d = ST_IDLE;
        endcase
    end

    // length of the phase being entered
    logic [7:0] len_h;
    always_comb begin
        case (st_d)
            ST_ALEAD: len_h = H_ADDR_LEAD;
            ST_ALE:   len_h = ale_h;
            ST_AHOLD: len_h = H_ALE_HOLD;
            ST_SLATE: len_h = H_BYTE2_LATE;
            ST_CSW:   len_h = csw_h;
            ST_STRB:  len_h = strb_h;
            ST_WHOLD: len_h = H_WR_HOLD;
            default:  len_h = 8'h00;
        endcase
    end

    wire       load     = (st_d != st_q) && (st_d != ST_IDLE);
    wire [7:0] load_cyc = emibs_cycles(len_h, ratio_one_q);               // see (RULE1)

    emibs_phase_timer u_timer (
        .clock    (clock),
        .arst_n   (arst_n),
        .load     (load),
        .load_val (load_cyc),
        .last     (last)
    );

    // pin values for the phase being entered
    wire       hi_byte   = second_q && (st_d != ST_SLATE);
    wire       addr_ph   = (st_d == ST_ALE) || (st_d == ST_AHOLD);
    wire       cs_n_d    = (st_d == ST_IDLE) || (st_d == ST_ALEAD);        // see (RULE8)
    wire       rd_n_d    = !((st_d == ST_STRB) && !w);                     // see (RULE5)
    wire       wr_n_d    = !((st_d == ST_STRB) && w);                      // see (RULE11)
    wire       ale_d     = (st_d == ST_ALE);
    wire       oe_d      = (st_d != ST_IDLE) && (w || (mux16_q && addr_ph));
    wire [15:0] wd       = (st_q == ST_IDLE) ? req_wdata : wdata_q;
    wire [ADDR_W-1:0] a  = (st_q == ST_IDLE) ? req_addr : addr_q;
    wire       byte2_go  = (st_q == ST_SLATE) && (st_d != ST_SLATE);       // see (RULE9)

    assign addr_d = start ? req_addr : byte2_go ? addr_q + 1'b1 : addr_q;
    assign dout_d = (mux16_q && addr_ph) ? a[15:0] :                       // see (RULE6)
                    mux16_q ? wd :
                    {8'h00, (hi_byte ? wd[15:8] : wd[7:0])};               // see (RULE10)

    // transfer context
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_q     <= ST_IDLE;
            wr_q     <= 1'b0;
            split_q  <= 1'b0;
            second_q <= 1'b0;
            wdata_q  <= 16'h0000;
        end else begin
            st_q <= st_d;
            if (start) begin
                wr_q     <= req_write;
                split_q  <= req_write && req_wide && !mux16_q;             // see (RULE9)
                second_q <= 1'b0;
                wdata_q  <= req_wdata;
            end else if (st_d == ST_SLATE) begin
                second_q <= 1'b1;
            end
        end
    end

    // registered pins and status
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cs_n_q  <= 1'b1;
            rd_n_q  <= 1'b1;
            wr_n_q  <= 1'b1;
            ale_q   <= 1'b0;
            oe_q    <= 1'b0;
            addr_q  <= '0;
            dout_q  <= 16'h0000;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            cs_n_q  <= cs_n_d;
            rd_n_q  <= rd_n_d;
            wr_n_q  <= wr_n_d;
            ale_q   <= ale_d;
            oe_q    <= oe_d;
            addr_q  <= addr_d;
            dout_q  <= dout_d;
            busy_q  <= (st_d != ST_IDLE);
            done_q  <= (st_q != ST_IDLE) && (st_d == ST_IDLE);
        end
    end

    // read data taken on the edge that ends the read strobe
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 16'h0000;
        end else if ((st_q == ST_STRB) && advance && !wr_q) begin
            rdata_q <= mux16_q ? mem_data_i : {8'h00, mem_data_i[7:0]};    // see (RULE12)
        end
    end

    assign busy           = busy_q;
    assign done           = done_q;
    assign rdata          = rdata_q;
    assign bus_ratio_one  = ratio_one_q;
    assign chip_select_n  = cs_n_q;
    assign read_strobe_n  = rd_n_q;
    assign write_strobe_n = wr_n_q;
    assign addr_latch     = ale_q;
    assign mem_addr       = addr_q;
    assign mem_data_o     = dout_q;
    assign mem_data_oe    = oe_q;
endmodule : emibs_sequencer
`default_nettype wire

// ---- bench/emibs_seq_props.sv ----
// concurrent checks on the memory bus sequencer pins
`timescale 1ns/10ps
`default_nettype none
module emibs_seq_props
    import emibs_pkg::*;
#(
    parameter int ADDR_W = 24
) (
    input wire logic              clock,
    input wire logic              arst_n,
    input wire logic              cfg_write,
    input wire logic              cfg_ratio_one,
    input wire logic              cfg_ale_two,
    input wire logic              cfg_mux16,
    input wire logic [4:0]        cfg_read_wait_count,
    input wire logic [4:0]        cfg_read_strobe_delay,
    input wire logic [4:0]        cfg_write_wait_count,
    input wire logic [4:0]        cfg_write_strobe_delay,
    input wire logic              req,
    input wire logic              busy,
    input wire logic              done,
    input wire logic              bus_ratio_one,
    input wire logic              chip_select_n,
    input wire logic              read_strobe_n,
    input wire logic              write_strobe_n,
    input wire logic              addr_latch,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [15:0]       mem_data_o,
    input wire logic              mem_data_oe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    logic       r1_q, a2_q, mx_q;
    logic [4:0] rw_q, rd_q, ww_q, wd_q;
    logic [7:0] st_q, lat_q, cs_q;
    // strobe length in clocks for a wait count and delay
    function automatic logic [7:0] slen(input logic [4:0] w,
                                        input logic [4:0] d,
                                        input logic       r1);
        logic [7:0] b;
        b = (w < d) ? 8'h01 : {3'h0, w - d} + 8'h01;
        slen = r1 ? b : {b[6:0], 1'b0};
    endfunction : slen
    // shadow of the setup and phase counters
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            {r1_q, a2_q, mx_q} <= {RATIO_ONE_RST, ALE_TWO_RST, MUX16_RST};
            {rw_q, rd_q, ww_q, wd_q} <= {RD_WAIT_RST, RD_DLY_RST, WR_WAIT_RST, WR_DLY_RST};
            {st_q, lat_q, cs_q} <= 24'h0;
        end else begin
            if (cfg_write && !busy && !req) begin
                {r1_q, a2_q, mx_q} <= {cfg_ratio_one, cfg_ale_two, cfg_mux16};
                {rw_q, rd_q} <= {cfg_read_wait_count, cfg_read_strobe_delay};
                {ww_q, wd_q} <= {cfg_write_wait_count, cfg_write_strobe_delay};
            end
            st_q <= (!read_strobe_n || !write_strobe_n) ? st_q + 8'h01 : 8'h00;
            lat_q <= addr_latch ? lat_q + 8'h01 : 8'h00;
            cs_q <= !chip_select_n ? cs_q + 8'h01 : 8'h00;
        end
    end
    sequence s_rd_end;
        $rose(read_strobe_n);
    endsequence
    sequence s_wr_end;
        $rose(write_strobe_n);
    endsequence
    property p_rd_cs;
        s_rd_end |-> $rose(chip_select_n) && done;
    endproperty
    a_rd_cs: assert property (p_rd_cs) else $error("select not freed with read");
    property p_rd_len;
        s_rd_end |-> st_q == slen(rw_q, rd_q, r1_q);
    endproperty
    a_rd_len: assert property (p_rd_len) else $error("read strobe length");
    property p_wr_len;
        s_wr_end |-> st_q == slen(ww_q, wd_q, r1_q);
    endproperty
    a_wr_len: assert property (p_wr_len) else $error("write strobe length");
    property p_wr_hold;
        s_wr_end |-> !chip_select_n && $stable(mem_addr) && $stable(mem_data_o);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write hold broken");
    property p_rd_dly;
        $fell(read_strobe_n) && !mx_q |-> cs_q == (r1_q ? {3'h0, rd_q} : {2'h0, rd_q, 1'b0});
    endproperty
    a_rd_dly: assert property (p_rd_dly) else $error("read strobe delay");
    property p_ale_mux;
        addr_latch |-> mem_data_oe && !chip_select_n && mem_data_o == mem_addr[15:0];
    endproperty
    a_ale_mux: assert property (p_ale_mux) else $error("address not on data lines");
    property p_ale_len;
        $fell(addr_latch) |-> lat_q == ((r1_q ? 8'h01 : 8'h02) << a2_q) && $stable(mem_data_o);
    endproperty
    a_ale_len: assert property (p_ale_len) else $error("latch strobe length");
    property p_ratio;
        bus_ratio_one == r1_q;
    endproperty
    a_ratio: assert property (p_ratio) else $error("bus clock ratio");
    property p_busy_done;
        $fell(busy) |-> done && chip_select_n;
    endproperty
    a_busy_done: assert property (p_busy_done) else $error("busy end without done");
    property p_strb_oe;
        !read_strobe_n || !write_strobe_n |-> (mem_data_oe == !write_strobe_n) && !chip_select_n;
    endproperty
    a_strb_oe: assert property (p_strb_oe) else $error("data drive during strobe");
endmodule : emibs_seq_props
bind emibs_sequencer emibs_seq_props #(.ADDR_W(ADDR_W)) u_props (.*);
`default_nettype wire

// ---- bench/emibs_mem_model.sv ----
// behavioural external static memory on the far side of the bus
`timescale 1ns/10ps
`default_nettype none
module emibs_mem_model (
    input wire logic        slow,
    input wire logic        chip_select_n,
    input wire logic        read_strobe_n,
    input wire logic        write_strobe_n,
    input wire logic        addr_latch,
    input wire logic [23:0] mem_addr,
    input wire logic [15:0] mem_data_o,
    output logic     [15:0] mem_data_i = 16'hffff
);
    logic [15:0] mem [logic [23:0]];
    logic [23:0] la = 24'h0;
    logic [15:0] last = 16'h0;
    logic        use_la = 1'b0;
    wire logic [23:0] a = use_la ? la : mem_addr;
    // low address taken from the data lines as the latch strobe ends
    always @(negedge addr_latch) begin
        if (chip_select_n === 1'b0) begin
            la = {mem_addr[23:16], mem_data_o};
            use_la = 1'b1;
        end
    end
    always @(posedge chip_select_n) use_la = 1'b0;
    // write data stored as the strobe ends
    always @(posedge write_strobe_n) if (chip_select_n === 1'b0) mem[a] = mem_data_o;
    // read data after a short or long access time, junk outside the strobe
    always @(negedge read_strobe_n) begin
        #(slow ? 40 : 5);
        if (!read_strobe_n) begin
            last = mem.exists(a) ? mem[a] : ~a[15:0];
            mem_data_i = last;
        end
    end
    always @(posedge read_strobe_n) mem_data_i = ~last;
endmodule : emibs_mem_model
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench of the memory bus sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import emibs_pkg::*;
    logic        clock = 1'b0, arst_n = 1'b0, slow = 1'b0, wide = 1'b0;
    logic        cfg_write = 1'b0, cfg_ratio_one = 1'b0, cfg_ale_two = 1'b0, cfg_mux16 = 1'b0;
    logic [4:0]  cfg_read_wait_count = 5'h1f, cfg_read_strobe_delay = 5'h01;
    logic [4:0]  cfg_write_wait_count = 5'h1f, cfg_write_strobe_delay = 5'h00;
    logic        req = 1'b0, req_write = 1'b0, req_wide = 1'b0;
    logic [23:0] req_addr = 24'h0, mem_addr, a;
    logic [15:0] req_wdata = 16'h0, rdata, mem_data_o, mem_data_i, d;
    logic        busy, done, bus_ratio_one, chip_select_n, read_strobe_n, write_strobe_n;
    logic        addr_latch, mem_data_oe;
    int          fails = 0;
    int          total_checks = 0;
    always #25 clock = ~clock;
    emibs_sequencer #(.ADDR_W(24)) i_dut (.*);
    emibs_mem_model i_mem (.*);
    task automatic tally_and_finish;
        if (fails == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // clocks taken by a phase of h half bus cycles
    function automatic int ck(input int h);
        return cfg_ratio_one ? (h + 1) / 2 : h;
    endfunction : ck
    function automatic int pos(input int x);
        return x > 0 ? x : 0;
    endfunction : pos
    // clocks from the taken request to done
    function automatic int exp_clk(input logic w, input logic wd);
        int dl;
        int wt;
        int s;
        int n;
        dl = w ? cfg_write_strobe_delay : cfg_read_strobe_delay;
        wt = w ? cfg_write_wait_count : cfg_read_wait_count;
        s = wt < dl ? 1 : wt - dl + 1;
        n = ck(2 * s) + ck(w);
        if (cfg_mux16) n += ck(2 << cfg_ale_two) + ck(1) + ck(pos(2 * dl - (2 << cfg_ale_two) - 1));
        else n += ck(w) + ck(2 * dl);
        if (w && wd && !cfg_mux16) n += 2 * ck(1) + ck(pos(2 * dl - 1)) + ck(2 * s);
        return n;
    endfunction : exp_clk
    // one transfer, timed from the taking edge to done
    task automatic xfer(input logic w, input logic wd, input logic [23:0] ad,
                        input logic [15:0] dat, input logic [15:0] exp);
        int n;
        @(posedge clock);
        #2;
        {req, req_write, req_wide, req_addr, req_wdata} = {1'b1, w, wd, ad, dat};
        @(posedge clock);
        #2;
        req = 1'b0;
        n = 0;
        while (done !== 1'b1) begin
            if (n > 900) begin
                fails++;
                tally_and_finish();
            end
            @(posedge clock);
            #2;
            n++;
        end
        chk(16'(n), 16'(exp_clk(w, wd)));
        chk({15'h0, chip_select_n}, 16'h0001);
        if (!w) chk(rdata, exp);
    endtask : xfer
    initial begin
        void'($urandom(88645));
        repeat (3) @(posedge clock);
        #2;
        arst_n = 1'b1;
        xfer(1'b0, 1'b0, 24'h00a5c3, 16'h0, 16'h003c);
        chk({15'h0, bus_ratio_one}, 16'h0000);
        for (int i = 0; i < 12; i++) begin
            @(posedge clock);
            #2;
            cfg_write = 1'b1;
            {cfg_ratio_one, cfg_ale_two, cfg_mux16} = 3'($urandom);
            {cfg_read_wait_count, cfg_read_strobe_delay} = 10'($urandom);
            {cfg_write_wait_count, cfg_write_strobe_delay} = 10'($urandom);
            if (i == 0) {cfg_write_wait_count, cfg_write_strobe_delay} = 10'h003;
            if (i == 1) {cfg_mux16, cfg_ale_two, cfg_read_strobe_delay} = 7'h65;
            if (i == 2) {cfg_ratio_one, cfg_mux16} = 2'h2;
            slow = i[0];
            a = 24'($urandom);
            d = 16'($urandom);
            wide = (i == 2) | 1'($urandom);
            @(posedge clock);
            #2;
            cfg_write = 1'b0;
            @(posedge clock);
            #2;
            chk({15'h0, bus_ratio_one}, {15'h0, cfg_ratio_one});
            xfer(1'b1, wide, a, d, 16'h0);
            xfer(1'b0, 1'b0, a, 16'h0, cfg_mux16 ? d : {8'h00, d[7:0]});
            if (wide && !cfg_mux16) xfer(1'b0, 1'b0, a + 24'h1, 16'h0, {8'h00, d[15:8]});
        end
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
